//--- hw/charger_ship_reset_status_ctrl.v
// Functional notes
// [RULE_01] Ship request turns the battery switch off at once or after delay.
// [RULE_02] With adapter, reset-with-input then ship request; ship mode on removal.
// [RULE_03] Ship mode exits on adapter, bit clear, register reset or button.
// [RULE_04] Full system reset only with reset enable 1 and ship request 0.
// [RULE_05] After full system reset all registers hold power-on defaults. Code keeps the high impedance enable bit at its prior value.
// [RULE_06] Button held low: switch off for off interval, then back on.
// [RULE_07] Reset-with-input 1: reset proceeds with adapter, high impedance first. Code enters high impedance in the same cycle the switch opens.
// [RULE_08] Reset-with-input 0: reset waits for button hold and adapter removal.
// [RULE_09] Power up after reset unless high impedance enable was set before.
// [RULE_10] Power good needs all five input qualifications true.
// [RULE_11] Indicator low charging, high idle, 1 Hz blink on suspend.
// [RULE_12] Each qualifying event gives one 256 us active-low alert pulse.
// [RULE_13] Alert events: input good, removal, source, done, faults, limits, top-off.
// [RULE_14] Flags latch until read; no alerts while latched; second read live.
// [RULE_15] Input overvoltage threshold defaults to highest, two-bit select.
// [RULE_16] Input overvoltage stops converter, no high impedance, fault 01, alert.
// [RULE_17] System overvoltage stops converter and enables rail discharge load.
// [RULE_18] Junction regulation: reduce current, no termination, half timer, flag.
// [RULE_19] Thermal shutdown off converter and switch, fault 10, resume at 130C.
// [RULE_20] Battery overvoltage stops switching, sets battery fault, alerts.
// [RULE_21] Discharge overcurrent latches switch off into ship mode.
// [RULE_22] I2C target at 6AH, registers 00h to 0Ch, beyond reads FFh.
// [RULE_23] I2C works at standard and fast rates.
// [RULE_24] Multi-byte access auto-increments the register address.
// [RULE_25] Undefined register address is not acknowledged, target goes idle.
// [RULE_26] Button synchronised and debounced before its low time is measured.
// [RULE_27] Blink and alert width come from internal timebase counters.
`timescale 1ns/10ps
`include "charger_supervisor_map.vh"

module charger_ship_reset_status_ctrl #(
  parameter US_CYCLES = `NS_PER_US / `CLK_PERIOD_NS,
  parameter US_PER_MS = `US_PER_MS,
  parameter ALERT_US = `ALERT_PULSE_US,
  parameter BLINK_HALF_MS = `BLINK_HALF_MS,
  parameter SHIP_DELAY_MS = `SHIP_ENTRY_DELAY_MS,
  parameter HOLD_MS = `BUTTON_RESET_HOLD_MS,
  parameter OFF_MS = `SWITCH_OFF_INTERVAL_MS,
  parameter DEGLITCH_MS = `SHIP_EXIT_DEGLITCH_MS,
  parameter DEBOUNCE_MS = `DEBOUNCE_MS,
  parameter [7:0] PART_INFO = `PART_INFO_DEFAULT // Arbitrary value
) (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire SCL,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire PUSH_BUTTON_N,
  input wire VBUS_ABOVE_UVLO,
  input wire VBUS_ABOVE_BAT,
  input wire VBUS_NOT_POOR,
  input wire SOURCE_DETECT_DONE,
  input wire [3:0] INPUT_OV_CMP,
  input wire SYS_OV_CMP,
  input wire BAT_OV_CMP,
  input wire DIE_ABOVE_110,
  input wire DIE_ABOVE_150,
  input wire DIE_BELOW_130,
  input wire DISCHARGE_OC,
  input wire CHARGING,
  input wire CHARGE_DONE,
  input wire TS_FAULT,
  input wire SAFETY_TIMER_FAULT,
  input wire TOPOFF_ACTIVE,
  input wire VINDPM_ACTIVE,
  input wire IINDPM_ACTIVE,
  output reg BATTERY_SWITCH_ON,
  output reg CONVERTER_ENABLE,
  output reg HIZ_MODE,
  output reg SYS_DISCHARGE_EN,
  output reg CHARGE_CURRENT_REDUCE,
  output reg TERMINATION_DISABLE,
  output reg TIMER_HALF_RATE,
  output wire STAT_OUT,
  output reg STAT_OE,
  output wire ALERT_N
);
  localparam SH_ON = 3'd0;
  localparam SH_DELAY = 3'd1;
  localparam SH_OFF_ADAPT = 3'd2;
  localparam SH_SHIP = 3'd3;
  localparam SH_RST_WAIT = 3'd4;
  localparam SH_RST_OFF = 3'd5;
  localparam [15:0] ALERT_CYCLES = ALERT_US * US_CYCLES;
  localparam [9:0] US_LAST = US_CYCLES - 1;
  localparam [9:0] MS_LAST = US_PER_MS - 1;
  localparam [15:0] DLY_LAST = SHIP_DELAY_MS - 1;
  localparam [15:0] HOLD_LAST = HOLD_MS - 1;
  localparam [15:0] OFF_LAST = OFF_MS - 1;
  localparam [15:0] DEGL_LAST = DEGLITCH_MS - 1;
  localparam [15:0] DEB_LAST = DEBOUNCE_MS - 1;
  localparam [15:0] BLINK_LAST = BLINK_HALF_MS - 1;

  // Every pin input except CLK_SYS and SYS_RST passes two flops before use
  wire [23:0] raw = {SCL, SDA_IN, PUSH_BUTTON_N, VBUS_ABOVE_UVLO,
    VBUS_ABOVE_BAT, VBUS_NOT_POOR, SOURCE_DETECT_DONE, INPUT_OV_CMP,
    SYS_OV_CMP, BAT_OV_CMP, DIE_ABOVE_110, DIE_ABOVE_150, DIE_BELOW_130,
    DISCHARGE_OC, CHARGING, CHARGE_DONE, TS_FAULT, SAFETY_TIMER_FAULT,
    TOPOFF_ACTIVE, VINDPM_ACTIVE, IINDPM_ACTIVE};
  reg [23:0] sync1;
  reg [23:0] sync2;
  wire scl_s = sync2[23];
  wire sda_s = sync2[22];
  wire btn_n_s = sync2[21];
  wire adapter = sync2[20];
  wire above_bat = sync2[19];
  wire not_poor = sync2[18];
  wire src_done = sync2[17];
  wire [3:0] ov_cmp = sync2[16:13];
  wire sys_ov = sync2[12];
  wire bat_ov = sync2[11];
  wire hot110 = sync2[10];
  wire hot150 = sync2[9];
  wire cool130 = sync2[8];
  wire dis_oc = sync2[7];
  wire charging = sync2[6];
  wire done = sync2[5];
  wire ts_fault = sync2[4];
  wire tmr_fault = sync2[3];
  wire topoff = sync2[2];
  wire vindpm = sync2[1];
  wire iindpm = sync2[0];

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sync1 <= 24'hE0_0000;
      sync2 <= 24'hE0_0000;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // Register file and I2C target
  reg [7:0] cfg [0:12];
  reg [7:0] tx_data;
  reg [7:0] fault_latch;
  reg [2:0] chg_latch;
  reg [2:0] state;
  wire [3:0] reg_addr;
  wire wr_en;
  wire [7:0] wr_data;
  wire rd_en;
  integer i;

  i2c_reg_target #(.ADDR(`TARGET_ADDR)) u_target ( // [RULE_23]
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .scl(scl_s),
    .sda(sda_s),
    .tx_data(tx_data),
    .sda_oe(SDA_OE),
    .reg_addr(reg_addr),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_en(rd_en)
  );
  assign SDA_OUT = 1'b0;

  function [7:0] por_value;
    input [3:0] idx;
    begin
      if (idx == `REG_INPUT_LIMIT)
        por_value = `RST_REG00;
      else if (idx == `REG_CTRL0)
        por_value = `RST_REG01;
      else if (idx == `REG_CTRL2)
        por_value = `RST_REG06;
      else if (idx == `REG_CTRL3)
        por_value = `RST_REG07;
      else
        por_value = `RST_OTHER;
    end
  endfunction

  wire input_high_impedance_enable = cfg[`REG_INPUT_LIMIT][`BIT_INPUT_HIGH_IMPEDANCE_ENABLE];
  wire ship_req = cfg[`REG_CTRL3][`BIT_SHIP_REQ];
  wire ship_dly = cfg[`REG_CTRL3][`BIT_SHIP_DLY];
  wire rst_wvbus = cfg[`REG_CTRL3][`BIT_RST_WVBUS];
  wire rst_en = cfg[`REG_CTRL3][`BIT_RST_EN];
  wire [1:0] ovp_sel = cfg[`REG_CTRL2][`BIT_OVP_MSB:`BIT_OVP_LSB];
  wire mask_vin = cfg[`REG_CHANGE][`BIT_MASK_VINDPM];
  wire mask_iin = cfg[`REG_CHANGE][`BIT_MASK_IINDPM];
  wire writable = (reg_addr <= `REG_CTRL3) || (reg_addr == `REG_LAST);
  wire reg_reset = wr_en && reg_addr == `REG_CTRL0 && wr_data[`BIT_REG_RST];

  // Timebase: microsecond and millisecond ticks
  reg [9:0] us_div;
  reg [9:0] ms_div;
  wire us_tick = (us_div == US_LAST);
  wire ms_tick = us_tick && (ms_div == MS_LAST);
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      us_div <= 10'h000;
      ms_div <= 10'h000;
    end else begin
      us_div <= us_tick ? 10'h000 : us_div + 10'h001;
      if (us_tick)
        ms_div <= (ms_div == MS_LAST) ? 10'h000 : ms_div + 10'h001;
    end
  end

  // Button debounce, then low-time measurement
  reg btn_deb_n;
  reg [15:0] deb_ms;
  reg [15:0] low_ms;
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      btn_deb_n <= 1'b1;
      deb_ms <= 16'h0000;
      low_ms <= 16'h0000;
    end else begin
      if (btn_n_s == btn_deb_n)
        deb_ms <= 16'h0000;
      else if (ms_tick && deb_ms == DEB_LAST) begin
        btn_deb_n <= btn_n_s; // [RULE_26]
        deb_ms <= 16'h0000;
      end else if (ms_tick)
        deb_ms <= deb_ms + 16'h0001;
      if (btn_deb_n)
        low_ms <= 16'h0000;
      else if (ms_tick && low_ms != 16'hFFFF)
        low_ms <= low_ms + 16'h0001;
    end
  end
  wire hold_hit = !btn_deb_n && ms_tick && low_ms == HOLD_LAST;
  wire degl_hit = !btn_deb_n && ms_tick && low_ms == DEGL_LAST;

  // Battery switch sequencing
  reg [2:0] next_state;
  reg [15:0] st_ms;
  reg ship_req_q;
  reg adapter_q;
  wire ship_req_fall = ship_req_q && !ship_req;
  wire adapter_rise = adapter && !adapter_q;
  wire adapter_fall = !adapter && adapter_q;
  wire ship_exit = adapter_rise || ship_req_fall || degl_hit; // [RULE_03]
  wire full_reset_done = state == SH_RST_OFF && ms_tick && st_ms == OFF_LAST;
  wire clear_ship = state == SH_SHIP && (adapter_rise || degl_hit);

  always @* begin
    next_state = state;
    case (state)
      SH_ON:
        if (dis_oc)
          next_state = SH_SHIP; // [RULE_21]
        else if (ship_req && (!adapter || rst_wvbus)) // [RULE_02]
          next_state = ship_dly ? SH_DELAY : // [RULE_01]
            (adapter ? SH_OFF_ADAPT : SH_SHIP);
        else if (rst_en && !ship_req && hold_hit) // [RULE_04] [RULE_06]
          next_state = (rst_wvbus || !adapter) ? SH_RST_OFF : // [RULE_07]
            SH_RST_WAIT;
      SH_DELAY:
        if (!ship_req)
          next_state = SH_ON;
        else if (ms_tick && st_ms == DLY_LAST)
          next_state = adapter ? SH_OFF_ADAPT : SH_SHIP; // [RULE_01]
      SH_OFF_ADAPT:
        if (!ship_req)
          next_state = SH_ON;
        else if (!adapter)
          next_state = SH_SHIP; // [RULE_02]
      SH_SHIP:
        if (ship_exit)
          next_state = SH_ON; // [RULE_03] [RULE_21]
      SH_RST_WAIT:
        if (!rst_en || ship_req)
          next_state = SH_ON;
        else if (!adapter)
          next_state = SH_RST_OFF; // [RULE_08]
      SH_RST_OFF:
        if (full_reset_done)
          next_state = SH_ON; // [RULE_06]
      default:
        next_state = SH_ON;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state <= SH_ON;
      st_ms <= 16'h0000;
      ship_req_q <= 1'b0;
      adapter_q <= 1'b0;
    end else begin
      state <= next_state;
      ship_req_q <= ship_req;
      adapter_q <= adapter;
      if (next_state != state)
        st_ms <= 16'h0000;
      else if (ms_tick)
        st_ms <= st_ms + 16'h0001;
    end
  end

  // Register writes; a full system reset restores defaults except the high impedance enable bit
  always @(posedge CLK_SYS) begin
    if (SYS_RST || reg_reset || full_reset_done) begin
      for (i = 0; i <= 12; i = i + 1)
        cfg[i] <= por_value(i[3:0]); // [RULE_05] [RULE_03]
      if (full_reset_done)
        cfg[`REG_INPUT_LIMIT][`BIT_INPUT_HIGH_IMPEDANCE_ENABLE] <= input_high_impedance_enable; // [RULE_09]
    end else begin
      if (wr_en && writable)
        cfg[reg_addr] <= (reg_addr == `REG_CTRL0) ?
          (wr_data & 8'h7F) : wr_data;
      else if (wr_en && reg_addr == `REG_CHANGE)
        cfg[`REG_CHANGE] <= {6'h00, wr_data[1:0]};
      if (clear_ship)
        cfg[`REG_CTRL3][`BIT_SHIP_REQ] <= 1'b0;
    end
  end

  // Protections
  reg tsd;
  wire input_overvoltage_event = ov_cmp[ovp_sel]; // [RULE_15]
  wire pg = adapter && above_bat && !input_overvoltage_event && not_poor && src_done; // [RULE_10]
  wire [1:0] chg_fault = tsd ? `FAULT_THERMAL : // [RULE_19]
    input_overvoltage_event ? `FAULT_INPUT_OV : // [RULE_16]
    tmr_fault ? `FAULT_TIMER : `FAULT_NONE;
  wire [7:0] fault_now = {2'b00, chg_fault, bat_ov, 2'b00, ts_fault}; // [RULE_20]
  wire suspend = input_overvoltage_event || ts_fault || tmr_fault || sys_ov;

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tsd <= 1'b0;
      BATTERY_SWITCH_ON <= 1'b1;
      CONVERTER_ENABLE <= 1'b0;
      HIZ_MODE <= 1'b0;
      SYS_DISCHARGE_EN <= 1'b0;
      CHARGE_CURRENT_REDUCE <= 1'b0;
      TERMINATION_DISABLE <= 1'b0;
      TIMER_HALF_RATE <= 1'b0;
    end else begin
      if (hot150)
        tsd <= 1'b1; // [RULE_19]
      else if (cool130)
        tsd <= 1'b0;
      BATTERY_SWITCH_ON <= !tsd && state != SH_OFF_ADAPT &&
        state != SH_SHIP && state != SH_RST_OFF;
      // Full system reset sets high impedance and stops converter in the same cycle the switch opens
      HIZ_MODE <= input_high_impedance_enable || state == SH_RST_OFF; // [RULE_07] [RULE_16]
      CONVERTER_ENABLE <= !(input_high_impedance_enable || state == SH_RST_OFF || input_overvoltage_event ||
        sys_ov || tsd || bat_ov); // [RULE_16] [RULE_17] [RULE_20]
      SYS_DISCHARGE_EN <= sys_ov; // [RULE_17]
      CHARGE_CURRENT_REDUCE <= hot110; // [RULE_18]
      TERMINATION_DISABLE <= hot110;
      TIMER_HALF_RATE <= hot110;
    end
  end

  // Charge indicator: open drain, driven low means "on"
  reg [15:0] blink_ms;
  reg blink;
  assign STAT_OUT = 1'b0;
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      blink_ms <= 16'h0000;
      blink <= 1'b0;
      STAT_OE <= 1'b0;
    end else begin
      if (ms_tick && blink_ms == BLINK_LAST) begin
        blink_ms <= 16'h0000;
        blink <= ~blink; // [RULE_27]
      end else if (ms_tick)
        blink_ms <= blink_ms + 16'h0001;
      STAT_OE <= suspend ? blink : charging; // [RULE_11]
    end
  end

  // Alert events, latched flags and pulse
  reg pg_q;
  reg src_q;
  reg done_q;
  reg topoff_q;
  reg vindpm_q;
  reg iindpm_q;
  reg [7:0] fault_q;
  reg [15:0] alert_cnt;
  wire topoff_evt = topoff != topoff_q;
  wire pg_rise = pg && !pg_q;
  wire src_rise = src_done && !src_q;
  wire event_any = pg_rise || adapter_fall || src_rise || // [RULE_13]
    (done && !done_q) || |(fault_now & ~fault_q) ||
    (vindpm && !vindpm_q && !mask_vin) ||
    (iindpm && !iindpm_q && !mask_iin) || topoff_evt;
  wire latched = |fault_latch || |chg_latch;
  wire rd_fault = rd_en && reg_addr == `REG_FAULT;
  wire rd_change = rd_en && reg_addr == `REG_CHANGE;
  assign ALERT_N = (alert_cnt == 16'h0000);

  always @(posedge CLK_SYS) begin
    if (SYS_RST || full_reset_done) begin
      pg_q <= 1'b0;
      src_q <= 1'b0;
      done_q <= 1'b0;
      topoff_q <= 1'b0;
      vindpm_q <= 1'b0;
      iindpm_q <= 1'b0;
      fault_q <= 8'h00;
      fault_latch <= 8'h00;
      chg_latch <= 3'h0;
      alert_cnt <= 16'h0000;
    end else begin
      pg_q <= pg;
      src_q <= src_done;
      done_q <= done;
      topoff_q <= topoff;
      vindpm_q <= vindpm;
      iindpm_q <= iindpm;
      fault_q <= fault_now;
      // Set wins over the read clear; a read leaves the live state
      fault_latch <= (rd_fault ? 8'h00 : fault_latch) | fault_now; // [RULE_14]
      chg_latch <= (rd_change ? 3'h0 : chg_latch) |
        {pg_rise, topoff_evt, src_rise};
      if (alert_cnt != 16'h0000)
        alert_cnt <= alert_cnt - 16'h0001;
      else if (event_any && !latched)
        alert_cnt <= ALERT_CYCLES; // [RULE_12] [RULE_14]
    end
  end

  // Read data for the target
  always @* begin
    if (reg_addr == `REG_STATUS0)
      tx_data = {charging, done, pg, hot110, tsd, input_overvoltage_event, sys_ov, topoff};
    else if (reg_addr == `REG_FAULT)
      tx_data = fault_latch;
    else if (reg_addr == `REG_CHANGE)
      tx_data = {1'b0, chg_latch, vindpm, iindpm, mask_vin, mask_iin};
    else if (reg_addr == `REG_PART)
      tx_data = PART_INFO;
    else if (reg_addr > `REG_LAST)
      tx_data = `READ_BEYOND; // [RULE_22]
    else
      tx_data = cfg[reg_addr];
  end
endmodule

//--- hw/charger_supervisor_map.vh
`ifndef CHARGER_SUPERVISOR_MAP_VH
`define CHARGER_SUPERVISOR_MAP_VH

// Register addresses
`define REG_INPUT_LIMIT 4'h0
`define REG_CTRL0 4'h1
`define REG_CTRL2 4'h6
`define REG_CTRL3 4'h7
`define REG_STATUS0 4'h8
`define REG_FAULT 4'h9
`define REG_CHANGE 4'hA
`define REG_PART 4'hB
`define REG_LAST 4'hC
`define READ_BEYOND 8'hFF
`define TARGET_ADDR 7'h6A

// Field positions
`define BIT_INPUT_HIGH_IMPEDANCE_ENABLE 7
`define BIT_REG_RST 7
`define BIT_OVP_MSB 7
`define BIT_OVP_LSB 6
`define BIT_RST_WVBUS 6
`define BIT_SHIP_REQ 5
`define BIT_SHIP_DLY 3
`define BIT_RST_EN 2
`define BIT_MASK_VINDPM 1
`define BIT_MASK_IINDPM 0

// Reset values
`define RST_REG00 8'h17
`define RST_REG01 8'h1A
`define RST_REG06 8'hC0
`define RST_REG07 8'h0C
`define RST_OTHER 8'h00
`define PART_INFO_DEFAULT 8'h5A

// Charge fault codes
`define FAULT_NONE 2'b00
`define FAULT_INPUT_OV 2'b01
`define FAULT_THERMAL 2'b10
`define FAULT_TIMER 2'b11

// Timing
`define CLK_PERIOD_NS 8
`define NS_PER_US 1000
`define US_PER_MS 1000
`define ALERT_PULSE_US 256
`define BLINK_HALF_MS 500
`define SHIP_ENTRY_DELAY_MS 10000
`define BUTTON_RESET_HOLD_MS 10000
`define SWITCH_OFF_INTERVAL_MS 250
`define SHIP_EXIT_DEGLITCH_MS 1000
`define DEBOUNCE_MS 2

`endif

//--- hw/i2c_reg_target.v
`timescale 1ns/10ps
`include "charger_supervisor_map.vh"

module i2c_reg_target #(
  parameter [6:0] ADDR = `TARGET_ADDR
) (
  input wire clk,
  input wire rst,
  input wire scl,
  input wire sda,
  input wire [7:0] tx_data,
  output reg sda_oe,
  output reg [3:0] reg_addr,
  output reg wr_en,
  output reg [7:0] wr_data,
  output reg rd_en
);
  localparam ST_IDLE = 4'd0;
  localparam ST_ADDR = 4'd1;
  localparam ST_ACK_ADDR = 4'd2;
  localparam ST_PTR = 4'd3;
  localparam ST_ACK_PTR = 4'd4;
  localparam ST_WDATA = 4'd5;
  localparam ST_ACK_DATA = 4'd6;
  localparam ST_RDATA = 4'd7;
  localparam ST_MACK = 4'd8;

  reg scl_q;
  reg sda_q;
  reg [3:0] state;
  reg [3:0] bits;
  reg [7:0] shift;
  reg rw;
  reg mack;

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop = scl & scl_q & ~sda_q & sda;

  always @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      bits <= 4'h0;
      shift <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_oe <= 1'b0;
      reg_addr <= 4'h0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      rd_en <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      if (start) begin
        state <= ST_ADDR;
        bits <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            shift <= {shift[6:0], sda};
            bits <= bits + 4'h1;
          end
          ST_MACK: begin
            mack <= ~sda;
            if (~sda)
              reg_addr <= reg_addr + 4'h1; // [RULE_24]
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR:
            if (bits == 4'h8) begin
              if (shift[7:1] == ADDR) begin // [RULE_22]
                sda_oe <= 1'b1;
                rw <= shift[0];
                state <= ST_ACK_ADDR;
              end else begin
                state <= ST_IDLE;
              end
            end
          ST_ACK_ADDR:
            if (rw) begin
              shift <= tx_data;
              sda_oe <= ~tx_data[7];
              rd_en <= 1'b1;
              bits <= 4'h1;
              state <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              bits <= 4'h0;
              state <= ST_PTR;
            end
          ST_PTR:
            if (bits == 4'h8) begin
              if (shift <= {4'h0, `REG_LAST}) begin
                reg_addr <= shift[3:0];
                sda_oe <= 1'b1;
                state <= ST_ACK_PTR;
              end else begin
                state <= ST_IDLE; // [RULE_25]
              end
            end
          ST_ACK_PTR, ST_ACK_DATA: begin
            if (state == ST_ACK_DATA)
              reg_addr <= reg_addr + 4'h1; // [RULE_24]
            sda_oe <= 1'b0;
            bits <= 4'h0;
            state <= ST_WDATA;
          end
          ST_WDATA:
            if (bits == 4'h8) begin
              wr_en <= 1'b1;
              wr_data <= shift;
              sda_oe <= 1'b1;
              state <= ST_ACK_DATA;
            end
          ST_RDATA:
            if (bits == 4'h8) begin
              sda_oe <= 1'b0;
              state <= ST_MACK;
            end else begin
              sda_oe <= ~shift[6];
              shift <= {shift[6:0], 1'b0};
              bits <= bits + 4'h1;
            end
          ST_MACK:
            if (mack) begin
              shift <= tx_data;
              sda_oe <= ~tx_data[7];
              rd_en <= 1'b1;
              bits <= 4'h1;
              state <= ST_RDATA;
            end else begin
              state <= ST_IDLE;
            end
          default: ;
        endcase
      end
    end
  end
endmodule

//--- verification/charger_ctrl_props.sv
`timescale 1ns/10ps
module charger_ctrl_checker #(
  parameter US_CYCLES = 125,
  parameter ALERT_US = 256
) (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire SCL,
  input wire SYS_OV_CMP,
  input wire BAT_OV_CMP,
  input wire DIE_ABOVE_110,
  input wire DIE_ABOVE_150,
  input wire [3:0] INPUT_OV_CMP,
  input wire SDA_OE,
  input wire ALERT_N,
  input wire BATTERY_SWITCH_ON,
  input wire CONVERTER_ENABLE,
  input wire HIZ_MODE,
  input wire SYS_DISCHARGE_EN,
  input wire CHARGE_CURRENT_REDUCE,
  input wire TERMINATION_DISABLE,
  input wire TIMER_HALF_RATE
);
  reg [15:0] low_cnt;
  always @(posedge CLK_SYS) begin
    if (SYS_RST || ALERT_N)
      low_cnt <= 16'h0000;
    else
      low_cnt <= low_cnt + 16'h0001;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  a_sysov_load: assert property (SYS_OV_CMP [*5] |-> SYS_DISCHARGE_EN)
    else $error("no discharge load");
  a_sysov_stop: assert property (SYS_OV_CMP [*5] |-> !CONVERTER_ENABLE)
    else $error("converter on in sys ov");
  a_die_reduce: assert property (DIE_ABOVE_110 [*5] |->
    CHARGE_CURRENT_REDUCE && TERMINATION_DISABLE && TIMER_HALF_RATE)
    else $error("no thermal regulation");
  a_die_clear: assert property (!DIE_ABOVE_110 [*5] |-> !CHARGE_CURRENT_REDUCE)
    else $error("current reduce stuck");
  a_thermal_off: assert property (DIE_ABOVE_150 [*5] |->
    !BATTERY_SWITCH_ON && !CONVERTER_ENABLE)
    else $error("shutdown incomplete");
  a_batov_stop: assert property (BAT_OV_CMP [*5] |-> !CONVERTER_ENABLE)
    else $error("converter on in bat ov");
  a_inov_stop: assert property (INPUT_OV_CMP[3] [*5] |->
    !CONVERTER_ENABLE && !HIZ_MODE)
    else $error("input ov response wrong");
  a_alert_width: assert property ($rose(ALERT_N) |->
    low_cnt == ALERT_US * US_CYCLES)
    else $error("alert pulse width wrong");
  a_sda_low: assert property ($changed(SDA_OE) |-> !SCL)
    else $error("SDA moved with SCL high");
endmodule
bind charger_ship_reset_status_ctrl charger_ctrl_checker #(
  .US_CYCLES(US_CYCLES), .ALERT_US(ALERT_US)) chk_u (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SCL(SCL),
  .SYS_OV_CMP(SYS_OV_CMP), .BAT_OV_CMP(BAT_OV_CMP),
  .DIE_ABOVE_110(DIE_ABOVE_110), .DIE_ABOVE_150(DIE_ABOVE_150),
  .INPUT_OV_CMP(INPUT_OV_CMP), .SDA_OE(SDA_OE), .ALERT_N(ALERT_N),
  .BATTERY_SWITCH_ON(BATTERY_SWITCH_ON), .HIZ_MODE(HIZ_MODE),
  .CONVERTER_ENABLE(CONVERTER_ENABLE), .SYS_DISCHARGE_EN(SYS_DISCHARGE_EN),
  .CHARGE_CURRENT_REDUCE(CHARGE_CURRENT_REDUCE),
  .TERMINATION_DISABLE(TERMINATION_DISABLE),
  .TIMER_HALF_RATE(TIMER_HALF_RATE));

//--- verification/i2c_host_model.sv
`timescale 1ns/10ps
module i2c_host_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // Clock stands high between frames; data line is pulled up when released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic start;
    #40 sda_oe = 1'b0;
    #40 scl = 1'b1;
    #40 sda_oe = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop;
    #40 sda_oe = 1'b1;
    #40 scl = 1'b1;
    #40 sda_oe = 1'b0;
    #40;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #40 sda_oe = !b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack,
                         output logic [7:0] q, output logic a);
    int i;
    for (i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack, a);
  endtask
endmodule

//--- verification/charger_ship_reset_status_ctrl_tb_top.sv
`timescale 1ns/10ps
module charger_ship_reset_status_ctrl_tb_top;
  logic clk, rst, btn_n, vin, sys_ov, bat_ov, d110, d150, inov, chg, aux;
  logic sda_ho, scl, sda_oe, bsw, conv, input_high_impedance_mode, dis, cur, stat_oe, alert_n;
  logic vb, vp, vs, oc, cd, tf, sf;
  logic [7:0] d0, d1;
  logic [6:0] row_in [7];
  logic [5:0] row_exp [7];
  int fails = 0;
  int tests_run = 0;
  int n;
  wire sda = !(sda_oe || sda_ho);
  charger_ship_reset_status_ctrl #(.US_CYCLES(4), .US_PER_MS(4),
    .BLINK_HALF_MS(4), .SHIP_DELAY_MS(5), .HOLD_MS(8), .OFF_MS(4),
    .DEGLITCH_MS(3), .DEBOUNCE_MS(2), .ALERT_US(256)) dut_u (
    .CLK_SYS(clk), .SYS_RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(),
    .SDA_OE(sda_oe), .PUSH_BUTTON_N(btn_n), .VBUS_ABOVE_UVLO(vin),
    .VBUS_ABOVE_BAT(vb), .VBUS_NOT_POOR(vp), .SOURCE_DETECT_DONE(vs),
    .INPUT_OV_CMP({4{inov}}), .SYS_OV_CMP(sys_ov), .BAT_OV_CMP(bat_ov),
    .DIE_ABOVE_110(d110), .DIE_ABOVE_150(d150), .DIE_BELOW_130(!d150),
    .DISCHARGE_OC(oc), .CHARGING(chg), .CHARGE_DONE(cd),
    .TS_FAULT(tf), .SAFETY_TIMER_FAULT(sf), .TOPOFF_ACTIVE(aux),
    .VINDPM_ACTIVE(aux), .IINDPM_ACTIVE(aux), .BATTERY_SWITCH_ON(bsw),
    .CONVERTER_ENABLE(conv), .HIZ_MODE(input_high_impedance_mode), .SYS_DISCHARGE_EN(dis),
    .CHARGE_CURRENT_REDUCE(cur), .TERMINATION_DISABLE(),
    .TIMER_HALF_RATE(), .STAT_OUT(), .STAT_OE(stat_oe), .ALERT_N(alert_n));
  i2c_host_model host_u (.scl(scl), .sda_oe(sda_ho), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_on(logic w, logic v, int lim);
    int i;
    for (i = 0; i < lim && (w ? alert_n : bsw) !== v; i++)
      tick(1);
    chk("wait", {7'h00, v}, {7'h00, w ? alert_n : bsw});
    if ((w ? alert_n : bsw) !== v)
      final_report();
  endtask
  task automatic addr(logic [7:0] p);
    logic [7:0] q;
    logic a;
    host_u.start();
    host_u.byte_io(8'hD4, 1'b1, q, a);
    chk("addr ack", 8'h00, {7'h00, a});
    host_u.byte_io(p, 1'b1, q, a);
    chk("ptr ack", {7'h00, p > 8'h0C}, {7'h00, a});
  endtask
  task automatic wr(logic [7:0] p, logic [7:0] v);
    logic [7:0] q;
    logic a;
    addr(p);
    host_u.byte_io(v, 1'b1, q, a);
    host_u.stop();
  endtask
  task automatic rd(logic [7:0] p);
    logic a;
    addr(p);
    host_u.start();
    host_u.byte_io(8'hD5, 1'b1, d0, a);
    host_u.byte_io(8'hFF, 1'b0, d0, a);
    host_u.byte_io(8'hFF, 1'b1, d1, a);
    host_u.stop();
  endtask
  initial begin
    {rst, btn_n, vin, vb, vp, vs} = 6'h3F;
    {sys_ov, bat_ov, d110, d150, inov, chg, aux, oc, cd, tf, sf} = 11'h000;
    // Inputs: system ov, battery ov, die 110, die 150, input ov, charging, aux
    row_in = '{7'h02, 7'h40, 7'h10, 7'h18, 7'h20, 7'h05, 7'h00};
    // Outputs: discharge, converter, reduce, switch, high-z, indicator
    row_exp = '{6'h15, 6'h24, 6'h1C, 6'h08, 6'h04, 6'h04, 6'h14};
    tick(2);
    rst = 1'b0;
    tick(1200);
    rd(8'h00);
    chk("reg00", 8'h17, d0);
    chk("reg01", 8'h1A, d1);
    rd(8'h06);
    chk("reg06", 8'hC0, d0);
    chk("reg07", 8'h0C, d1);
    rd(8'h09);
    rd(8'h09);
    bat_ov = 1'b1;
    wait_on(1'b1, 1'b0, 20);
    bat_ov = 1'b0;
    tick(1100);
    rd(8'h09);
    chk("fault latched", 8'h08, d0);
    rd(8'h09);
    chk("fault live", 8'h00, d0);
    for (n = 0; n < 7; n++) begin
      {sys_ov, bat_ov, d110, d150, inov, chg, aux} = row_in[n];
      tick(10);
      chk("discharge", {7'h00, row_exp[n][5]}, {7'h00, dis});
      chk("converter", {7'h00, row_exp[n][4]}, {7'h00, conv});
      chk("reduce", {7'h00, row_exp[n][3]}, {7'h00, cur});
      chk("switch", {7'h00, row_exp[n][2]}, {7'h00, bsw});
      chk("high z", {7'h00, row_exp[n][1]}, {7'h00, input_high_impedance_mode});
      if (!(row_in[n][6] || row_in[n][2]))
        chk("indicator", {7'h00, row_exp[n][0]}, {7'h00, stat_oe});
    end
    rd(8'h0C);
    chk("beyond", 8'hFF, d1);
    addr(8'h0D);
    host_u.stop();
    vin = 1'b0;
    wr(8'h07, 8'h24);
    wait_on(1'b0, 1'b0, 40);
    btn_n = 1'b0;
    wait_on(1'b0, 1'b1, 400);
    btn_n = 1'b1;
    rd(8'h07);
    chk("ship cleared", 8'h04, d0);
    tick(100);
    btn_n = 1'b0;
    wait_on(1'b0, 1'b0, 400);
    wait_on(1'b0, 1'b1, 200);
    btn_n = 1'b1;
    rd(8'h07);
    chk("after reset", 8'h0C, d0);
    oc = 1'b1;
    wait_on(1'b0, 1'b0, 20);
    {oc, vin} = 2'b01;
    wait_on(1'b0, 1'b1, 20);
    final_report();
  end
endmodule
